// ==== sld_driver.sv ====
/*
  Eight-stage serial-in shift register, transparent output latches and
  output blanking, sampled from host pins on the 100 MHz system clock.
  Assumes the four host pins are asynchronous to clock and that the host
  shift clock runs far slower than clock. Captured bits pass a 32-entry FIFO
  before the shift stages so a user-side hold can stall shifting.
*/
`timescale 1ns/1ps

module sld_driver
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host pins
  input wire logic serial_in,
  input wire logic shift_clock,
  input wire logic strobe,
  input wire logic output_enable_n,
  // Driver outputs
  output logic [SLD_STAGES-1:0] drive_out,
  output logic serial_out,
  // User-side flow control
  input wire logic shift_hold,
  output logic capture_ready,
  // Status
  output logic overrun,
  output logic setup_violation,
  output logic hold_violation,
  output logic clock_width_violation,
  output logic strobe_spacing_violation,
  output logic strobe_width_violation
);
  logic [SLD_PINS-1:0] sync_a;
  logic [SLD_PINS-1:0] sync_b;
  logic [SLD_PINS-1:0] pin_prev;
  logic data_s;
  logic sclk_s;
  logic stb_s;
  logic oe_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic stb_rise;
  logic stb_fall;
  logic data_change;

  logic [SLD_CNT_W-1:0] data_age;
  logic [SLD_CNT_W-1:0] since_rise;
  logic [SLD_CNT_W-1:0] sclk_high;
  logic [SLD_CNT_W-1:0] stb_high;
  logic hold_watch;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [SLD_FIFO_WIDTH-1:0] fifo_out_data;
  logic shift_step;

  logic [SLD_STAGES-1:0] shift_reg;
  logic [SLD_STAGES-1:0] latch_reg;

  // Two-flop synchronisers, one per host pin
  genvar gi;
  generate
    for (gi = 0; gi < SLD_PINS; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (reset) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= (gi == SLD_PIN_DATA) ? serial_in :
                        (gi == SLD_PIN_SCLK) ? shift_clock :
                        (gi == SLD_PIN_STB) ? strobe : output_enable_n;
          sync_b[gi] <= sync_a[gi];
          pin_prev[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  assign data_s = sync_b[SLD_PIN_DATA];
  assign sclk_s = sync_b[SLD_PIN_SCLK];
  assign stb_s = sync_b[SLD_PIN_STB];
  assign oe_n_s = sync_b[SLD_PIN_OE_N];
  assign sclk_rise = sclk_s && !pin_prev[SLD_PIN_SCLK];
  assign sclk_fall = !sclk_s && pin_prev[SLD_PIN_SCLK];
  assign stb_rise = stb_s && !pin_prev[SLD_PIN_STB];
  assign stb_fall = !stb_s && pin_prev[SLD_PIN_STB];
  assign data_change = data_s != pin_prev[SLD_PIN_DATA];

  // Cycles since serial data last changed
  always_ff @(posedge clock) begin
    if (reset) begin
      data_age <= SLD_CNT_MAX;
    end else if (data_change) begin
      data_age <= '0;
    end else if (data_age != SLD_CNT_MAX) begin
      data_age <= data_age + 1'b1;
    end
  end

  // Cycles since the last rising shift-clock edge
  always_ff @(posedge clock) begin
    if (reset) begin
      since_rise <= SLD_CNT_MAX;
    end else if (sclk_rise) begin
      since_rise <= '0;
    end else if (since_rise != SLD_CNT_MAX) begin
      since_rise <= since_rise + 1'b1;
    end
  end

  // Shift-clock high time
  always_ff @(posedge clock) begin
    if (reset) begin
      sclk_high <= '0;
    end else if (sclk_rise) begin
      sclk_high <= 8'h01;
    end else if (sclk_s && sclk_high != SLD_CNT_MAX) begin
      sclk_high <= sclk_high + 1'b1;
    end
  end

  // Strobe high time
  always_ff @(posedge clock) begin
    if (reset) begin
      stb_high <= '0;
    end else if (stb_rise) begin
      stb_high <= 8'h01;
    end else if (stb_s && stb_high != SLD_CNT_MAX) begin
      stb_high <= stb_high + 1'b1;
    end
  end

  // Data must settle before the capturing edge
  always_ff @(posedge clock) begin
    if (reset) begin
      setup_violation <= 1'b0;
    end else if (sclk_rise && (data_change || data_age < SLD_SETUP_CYC)) begin
      setup_violation <= 1'b1;
    end
  end

  // Data must stay put for a while after the edge
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_watch <= 1'b0;
    end else if (sclk_rise) begin
      hold_watch <= 1'b1;
    end else if (since_rise >= SLD_HOLD_CYC) begin
      hold_watch <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hold_violation <= 1'b0;
    end else if (hold_watch && data_change && since_rise < SLD_HOLD_CYC) begin
      hold_violation <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      clock_width_violation <= 1'b0;
    end else if (sclk_fall && sclk_high < SLD_CLK_WIDTH_CYC) begin
      clock_width_violation <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      strobe_spacing_violation <= 1'b0;
    end else if (stb_rise && since_rise < SLD_CLK_TO_STB_CYC) begin
      strobe_spacing_violation <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      strobe_width_violation <= 1'b0;
    end else if (stb_fall && stb_high < SLD_STB_WIDTH_CYC) begin
      strobe_width_violation <= 1'b1;
    end
  end

  // Bit lost when an edge finds the FIFO full
  always_ff @(posedge clock) begin
    if (reset) begin
      overrun <= 1'b0;
    end else if (sclk_rise && !fifo_in_ready) begin
      overrun <= 1'b1;
    end
  end

  assign capture_ready = fifo_in_ready;
  assign fifo_out_ready = !shift_hold;
  assign shift_step = fifo_out_valid && fifo_out_ready;

  sld_fifo #(
    .WIDTH(SLD_FIFO_WIDTH),
    .DEPTH(SLD_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(sclk_rise),
    .in_ready(fifo_in_ready),
    .in_data(data_s),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Shift register, stage 0 first, last stage feeds the cascade pin
  always_ff @(posedge clock) begin
    if (reset) begin
      shift_reg <= SLD_STAGES_RESET;
    end else if (shift_step) begin
      shift_reg <= {shift_reg[SLD_STAGES-2:0], fifo_out_data[0]};
    end
  end

  // Transparent latches while strobe is high
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_reg <= SLD_STAGES_RESET;
    end else if (stb_s) begin
      latch_reg <= shift_reg;
    end
  end

  // Output blanking
  always_ff @(posedge clock) begin
    if (reset) begin
      drive_out <= SLD_STAGES_RESET;
    end else if (oe_n_s) begin
      drive_out <= SLD_STAGES_RESET;
    end else begin
      drive_out <= latch_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= shift_reg[SLD_STAGES-1];
    end
  end
endmodule

// ==== sld_driver_props.sv ====
/*
  Port checks for the serial-in latched driver.
  Assumes binding to sld_driver and a host that keeps legal pin timing.
*/
`timescale 1ns/1ps
module sld_driver_props
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host pins
  input wire logic shift_clock,
  input wire logic strobe,
  input wire logic output_enable_n,
  // Outputs and flow control
  input wire logic [SLD_STAGES-1:0] drive_out,
  input wire logic serial_out,
  input wire logic shift_hold,
  input wire logic capture_ready,
  input wire logic overrun
);
  logic [5:0] quiet;
  // Idle cycles: shift clock low, no stall
  always_ff @(posedge clock) begin
    if (reset || shift_clock || shift_hold) begin
      quiet <= 6'h00;
    end else if (quiet != 6'h3f) begin
      quiet <= quiet + 6'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_full_rise;
    $rose(shift_clock) ##0 (shift_hold && !capture_ready)[*8];
  endsequence
  sequence s_settled;
    quiet == 6'h3f;
  endsequence
  a_blank_outputs: assert property (output_enable_n[*5] |-> drive_out == '0)
    else $error("outputs not blanked");
  a_latch_hold: assert property ((!strobe && !output_enable_n)[*8] |-> $stable(drive_out))
    else $error("latch changed with strobe low");
  a_sout_quiet: assert property (s_settled |-> $stable(serial_out))
    else $error("cascade output moved without shifting");
  a_latch_follow: assert property ((strobe && !output_enable_n && quiet == 6'h3f)[*8]
    |-> drive_out[SLD_STAGES-1] == serial_out)
    else $error("last latch differs from last stage");
  a_overrun_set: assert property (s_full_rise |-> overrun)
    else $error("dropped bit not flagged");
  a_overrun_sticky: assert property (overrun |=> overrun)
    else $error("overrun flag cleared");
  a_ready_stall: assert property ($fell(capture_ready) |-> $past(shift_hold))
    else $error("buffer filled without a stall");
  a_ready_drain: assert property (s_settled |-> capture_ready)
    else $error("buffer not drained");
endmodule

// ==== sld_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sld_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ==== sld_host.sv ====
/*
  Host model driving the four driver pins.
  Assumes the 100 MHz bench clock; pin timing stays well inside limits.
*/
`timescale 1ns/1ps
module sld_host (
  // Clock
  input wire logic clock,
  // Pins
  output logic serial_in,
  output logic shift_clock,
  output logic strobe,
  output logic output_enable_n
);
  initial begin
    serial_in = 1'b0;
    shift_clock = 1'b0;
    strobe = 1'b0;
    output_enable_n = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic send_bit(input logic b);
    idle(1);
    serial_in <= b;
    idle(10);
    shift_clock <= 1'b1;
    idle(16);
    shift_clock <= 1'b0;
    // Released data shows the inverse
    serial_in <= ~b;
    idle(16);
  endtask
  task automatic set_strobe(input logic v);
    idle(32);
    strobe <= v;
    idle(12);
  endtask
  task automatic set_oe_n(input logic v);
    idle(1);
    output_enable_n <= v;
  endtask
endmodule

// ==== sld_notes_unused.sv ====
/*
  Intentionally empty.
*/

// ==== sld_pkg.sv ====
/*
  Constants shared by the serial-in latched driver and its bit FIFO.
  Assumes a single 100 MHz system clock; all pin times are converted to cycles here.
*/
package sld_pkg;
  localparam int SLD_STAGES = 8;
  localparam int SLD_FIFO_DEPTH = 32;
  localparam int SLD_FIFO_WIDTH = 1;
  localparam int SLD_CLK_MHZ = 100;
  localparam int SLD_SYNC_STAGES = 2;
  localparam int SLD_CNT_W = 8;

  // Pin timing minimums in ns
  localparam int SLD_SETUP_NS = 75;
  localparam int SLD_HOLD_NS = 75;
  localparam int SLD_CLK_WIDTH_NS = 150;
  localparam int SLD_CLK_TO_STB_NS = 300;
  localparam int SLD_STB_WIDTH_NS = 100;

  // Least times round up to whole cycles
  localparam logic [SLD_CNT_W-1:0] SLD_SETUP_CYC =
    SLD_CNT_W'((SLD_SETUP_NS * SLD_CLK_MHZ + 999) / 1000);
  localparam logic [SLD_CNT_W-1:0] SLD_HOLD_CYC =
    SLD_CNT_W'((SLD_HOLD_NS * SLD_CLK_MHZ + 999) / 1000);
  localparam logic [SLD_CNT_W-1:0] SLD_CLK_WIDTH_CYC =
    SLD_CNT_W'((SLD_CLK_WIDTH_NS * SLD_CLK_MHZ + 999) / 1000);
  localparam logic [SLD_CNT_W-1:0] SLD_CLK_TO_STB_CYC =
    SLD_CNT_W'((SLD_CLK_TO_STB_NS * SLD_CLK_MHZ + 999) / 1000);
  localparam logic [SLD_CNT_W-1:0] SLD_STB_WIDTH_CYC =
    SLD_CNT_W'((SLD_STB_WIDTH_NS * SLD_CLK_MHZ + 999) / 1000);

  localparam logic [SLD_CNT_W-1:0] SLD_CNT_MAX = 8'hff;
  localparam logic [SLD_STAGES-1:0] SLD_STAGES_RESET = 8'h00;

  // Pin bit positions inside the synchroniser vector
  localparam int SLD_PIN_DATA = 0;
  localparam int SLD_PIN_SCLK = 1;
  localparam int SLD_PIN_STB = 2;
  localparam int SLD_PIN_OE_N = 3;
  localparam int SLD_PINS = 4;
endpackage

// ==== tb.sv ====
/*
  Self-checking bench for the serial-in latched driver.
  Assumes the host model keeps legal pin timing; a model here predicts outputs.
*/
`timescale 1ns/1ps
module tb;
  import sld_pkg::*;
  logic clock;
  logic reset;
  logic shift_hold;
  logic serial_in;
  logic shift_clock;
  logic strobe;
  logic output_enable_n;
  logic [SLD_STAGES-1:0] drive_out;
  logic serial_out;
  logic capture_ready;
  logic overrun;
  logic setup_violation;
  logic hold_violation;
  logic clock_width_violation;
  logic strobe_spacing_violation;
  logic strobe_width_violation;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int sr = 0;
  int lt = 0;
  int held = 0;
  int strobe_on = 0;
  int blank = 0;

  sld_host u_host (.clock(clock), .serial_in(serial_in), .shift_clock(shift_clock),
    .strobe(strobe), .output_enable_n(output_enable_n));
  sld_driver u_sld_driver (.clock(clock), .reset(reset), .serial_in(serial_in),
    .shift_clock(shift_clock), .strobe(strobe), .output_enable_n(output_enable_n),
    .drive_out(drive_out), .serial_out(serial_out), .shift_hold(shift_hold),
    .capture_ready(capture_ready), .overrun(overrun), .setup_violation(setup_violation),
    .hold_violation(hold_violation), .clock_width_violation(clock_width_violation),
    .strobe_spacing_violation(strobe_spacing_violation),
    .strobe_width_violation(strobe_width_violation));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Model: bit0 first stage, bit7 last; stalled bits beyond depth dropped
  task automatic shift(input int b);
    u_host.send_bit(b[0]);
    if (shift_hold !== 1'b1 || held < SLD_FIFO_DEPTH) begin
      sr = ((sr << 1) | (b & 1)) & 8'hff;
      held += int'(shift_hold);
      if (strobe_on != 0) lt = sr;
    end
  endtask
  task automatic send_byte(input int v);
    for (int i = 7; i >= 0; i--) shift(v >> i);
  endtask
  task automatic latch();
    u_host.set_strobe(1'b1);
    u_host.set_strobe(1'b0);
    lt = sr;
  endtask
  task automatic set_oe_n(input int v);
    u_host.set_oe_n(v[0]);
    blank = v;
  endtask
  task automatic verify();
    repeat (80) @(posedge clock);
    check(drive_out, (blank != 0) ? 8'h00 : 8'(lt));
    check({7'h00, serial_out}, 8'((sr >> 7) & 1));
  endtask

  initial begin
    reset = 1'b1;
    shift_hold = 1'b0;
    void'($urandom(73));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    verify();
    repeat (3) begin
      send_byte($urandom);
      verify();
      latch();
      verify();
    end
    set_oe_n(1);
    verify();
    send_byte($urandom);
    latch();
    set_oe_n(0);
    verify();
    // Strobe held high: outputs blanked during entry
    set_oe_n(1);
    u_host.set_strobe(1'b1);
    strobe_on = 1;
    lt = sr;
    send_byte($urandom);
    set_oe_n(0);
    verify();
    shift($urandom);
    verify();
    u_host.set_strobe(1'b0);
    strobe_on = 0;
    // Stall until the buffer refuses, then drain
    @(posedge clock);
    shift_hold <= 1'b1;
    held = 0;
    repeat (SLD_FIFO_DEPTH + 2) shift($urandom);
    check({6'h00, capture_ready, overrun}, 8'h01);
    @(posedge clock);
    shift_hold <= 1'b0;
    verify();
    check({6'h00, capture_ready, overrun}, 8'h03);
    latch();
    verify();
    // Legal host timing never raises a timing violation flag
    check({3'h0, setup_violation, hold_violation, clock_width_violation,
      strobe_spacing_violation, strobe_width_violation}, 8'h00);
    close_out();
  end
endmodule

bind sld_driver sld_driver_props u_props (.clock(clock), .reset(reset),
  .shift_clock(shift_clock), .strobe(strobe), .output_enable_n(output_enable_n),
  .drive_out(drive_out), .serial_out(serial_out), .shift_hold(shift_hold),
  .capture_ready(capture_ready), .overrun(overrun));
